//--- wdpcs_cfg.svh
// constant definitions for the protected watchdog
`ifndef WDPCS_CFG_SVH
`define WDPCS_CFG_SVH

`define WDP_MCLK_HZ        50000000
`define WDP_SLOW_HZ        125000
`define WDP_AW             5
`define WDP_A_REFRESH      5'h00
`define WDP_A_START        5'h04
`define WDP_A_PROTECT      5'h08
`define WDP_A_CLKCTRL      5'h0C
`define WDP_A_PMODE        5'h10
`define WDP_A_WDCTRL       5'h14
`define WDP_A_STATUS       5'h18
`define WDP_CW             15
`define WDP_RELOAD_NORM    15'h7FFF
`define WDP_RELOAD_PROT    15'h0FFF
`define WDP_REFRESH_ARM    8'h00
`define WDP_REFRESH_FIRE   8'hFF
`define WDP_OPT_AUTOSTART  0
`define WDP_OPT_PROTECT    7
`define WDP_B_PROTECT      0
`define WDP_B_STOP_REQ     0
`define WDP_B_SLOW_STOP    4
`define WDP_B_UF_ACTION    2
`define WDP_B_PRE_RATIO    7
`define WDP_DIV_LO         7'h0F
`define WDP_DIV_HI         7'h7F

`endif

//--- wdpcs_pkg.sv
// types shared by the protected watchdog
`default_nettype none
package wdpcs_pkg;

    typedef struct packed {
        logic protect;
        logic stop_req;
        logic slow_stop;
        logic uf_action;
        logic pre_ratio;
    } wdpcs_ctrl_t;

    typedef enum logic [1:0] {
        WDPCS_ARM_IDLE = 2'h1,
        WDPCS_ARM_GOT0 = 2'h2
    } wdpcs_arm_t;

endpackage : wdpcs_pkg
`default_nettype wire

//--- wdpcs_prescaler.sv
// cpu clock prescaler, divide by 16 or 128
`default_nettype none
`include "wdpcs_cfg.svh"
module wdpcs_prescaler (
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // control
    input  wire logic enable,
    input  wire logic ratio_sel,
    // output
    output logic      tick
);
    logic [6:0] cnt_reg;
    logic [6:0] last;

    assign last = ratio_sel ? `WDP_DIV_HI : `WDP_DIV_LO;
    assign tick = enable && (cnt_reg >= last);

    // cleared by reset and at the end of each period, never by a refresh
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_reg <= 7'h00;
        end else if (enable) begin
            cnt_reg <= tick ? 7'h00 : cnt_reg + 7'h01;
        end
    end
endmodule : wdpcs_prescaler
`default_nettype wire

//--- wdpcs_top.sv
// watchdog with count source protection, avalon-mm registers
`default_nettype none
`include "wdpcs_cfg.svh"

module wdpcs_top #(
    parameter int SLOW_DIV = `WDP_MCLK_HZ / `WDP_SLOW_HZ
) (
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                resetn,
    // avalon-mm slave
    input  wire logic [`WDP_AW-1:0]  avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    // option word and system state
    input  wire logic [7:0]          boot_option_word,
    input  wire logic                cpu_clock_run,
    input  wire logic                wait_mode,
    input  wire logic                stop_wake,
    // system outputs
    output logic                     stop_mode_req,
    output logic                     slow_osc_run,
    output logic                     wdt_reset,
    output logic                     wdt_irq
);
    wdpcs_pkg::wdpcs_ctrl_t ctrl_reg;
    wdpcs_pkg::wdpcs_arm_t  arm_reg;
    logic [`WDP_CW-1:0]     count_reg;
    logic [`WDP_CW-1:0]     count_next;
    logic [7:0]             opt_reg;
    logic                   running_reg;
    logic                   ack_reg;
    logic [31:0]            readdata_reg;
    logic                   wdt_reset_reg;
    logic                   wdt_irq_reg;
    logic [15:0]            slow_cnt_reg;
    logic                   slow_tick;
    logic                   pre_tick;
    logic                   pre_en;
    logic                   tick;
    logic                   underflow;
    logic                   wr_acc;
    logic                   rd_acc;
    logic                   refresh_fire;
    logic                   protect_set;
    logic                   stopped;

    // register decode
    function automatic logic hit(input logic [`WDP_AW-1:0] a, input logic [`WDP_AW-1:0] r);
        hit = (a == r);
    endfunction : hit

    // one wait state per access
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    assign wr_acc          = avs_write && ack_reg;
    assign rd_acc          = avs_read && ack_reg;
    assign avs_readdata    = readdata_reg;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read && !ack_reg) begin
            readdata_reg <= 32'h0000_0000;
            case (1'b1)
                hit(avs_address, `WDP_A_PROTECT): begin
                    readdata_reg[`WDP_B_PROTECT] <= ctrl_reg.protect;
                end
                hit(avs_address, `WDP_A_CLKCTRL): begin
                    readdata_reg[`WDP_B_STOP_REQ]  <= ctrl_reg.stop_req;
                    readdata_reg[`WDP_B_SLOW_STOP] <= ctrl_reg.slow_stop;
                end
                hit(avs_address, `WDP_A_PMODE): begin
                    readdata_reg[`WDP_B_UF_ACTION] <= ctrl_reg.uf_action;
                end
                hit(avs_address, `WDP_A_WDCTRL): begin
                    readdata_reg[4:0]              <= count_reg[`WDP_CW-1:`WDP_CW-5];
                    readdata_reg[`WDP_B_PRE_RATIO] <= ctrl_reg.pre_ratio;
                end
                hit(avs_address, `WDP_A_STATUS): begin
                    readdata_reg[`WDP_CW-1:0] <= count_reg;
                    readdata_reg[16]          <= running_reg;
                    readdata_reg[31:24]       <= opt_reg;
                end
                default: begin
                    readdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    // option word caught while reset is held, no program path
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            opt_reg <= boot_option_word;
        end
    end

    assign protect_set = wr_acc && hit(avs_address, `WDP_A_PROTECT)
                         && avs_writedata[`WDP_B_PROTECT] && !ctrl_reg.protect;

    // control bits with protection side effects
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl_reg.protect   <= !boot_option_word[`WDP_OPT_PROTECT];
            ctrl_reg.stop_req  <= 1'b0;
            ctrl_reg.slow_stop <= !boot_option_word[`WDP_OPT_PROTECT] ? 1'b0 : 1'b1;
            ctrl_reg.uf_action <= !boot_option_word[`WDP_OPT_PROTECT];
            ctrl_reg.pre_ratio <= 1'b0;
        end else begin
            if (protect_set) begin
                ctrl_reg.protect   <= 1'b1;
                ctrl_reg.slow_stop <= 1'b0;
                ctrl_reg.uf_action <= 1'b1;
            end
            if (wr_acc && hit(avs_address, `WDP_A_CLKCTRL) && !ctrl_reg.protect) begin
                ctrl_reg.stop_req  <= avs_writedata[`WDP_B_STOP_REQ];
                ctrl_reg.slow_stop <= avs_writedata[`WDP_B_SLOW_STOP];
            end else if (stop_wake) begin
                ctrl_reg.stop_req  <= 1'b0;
            end
            if (wr_acc && hit(avs_address, `WDP_A_PMODE) && !ctrl_reg.protect) begin
                ctrl_reg.uf_action <= avs_writedata[`WDP_B_UF_ACTION];
            end
            if (wr_acc && hit(avs_address, `WDP_A_WDCTRL)) begin
                ctrl_reg.pre_ratio <= avs_writedata[`WDP_B_PRE_RATIO];
            end
        end
    end

    // stop mode never granted while protected
    assign stop_mode_req = ctrl_reg.stop_req && !ctrl_reg.protect;
    assign stopped       = stop_mode_req;
    assign slow_osc_run  = !ctrl_reg.slow_stop;

    // start state after reset, start register write
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            running_reg <= !boot_option_word[`WDP_OPT_AUTOSTART];
        end else if (wr_acc && hit(avs_address, `WDP_A_START)) begin
            running_reg <= 1'b1;
        end
    end

    // refresh sequence
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            arm_reg <= wdpcs_pkg::WDPCS_ARM_IDLE;
        end else if (wr_acc && hit(avs_address, `WDP_A_REFRESH)) begin
            case (arm_reg)
                wdpcs_pkg::WDPCS_ARM_IDLE: begin
                    if (avs_writedata[7:0] == `WDP_REFRESH_ARM) begin
                        arm_reg <= wdpcs_pkg::WDPCS_ARM_GOT0;
                    end
                end
                wdpcs_pkg::WDPCS_ARM_GOT0: begin
                    if (avs_writedata[7:0] != `WDP_REFRESH_ARM) begin
                        arm_reg <= wdpcs_pkg::WDPCS_ARM_IDLE;
                    end
                end
                default: begin
                    arm_reg <= wdpcs_pkg::WDPCS_ARM_IDLE;
                end
            endcase
        end
    end

    assign refresh_fire = wr_acc && hit(avs_address, `WDP_A_REFRESH)
                          && (arm_reg == wdpcs_pkg::WDPCS_ARM_GOT0)
                          && (avs_writedata[7:0] == `WDP_REFRESH_FIRE);

    // slow on-chip oscillator as enable pulse
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            slow_cnt_reg <= 16'h0000;
        end else if (!slow_osc_run || slow_tick) begin
            slow_cnt_reg <= 16'h0000;
        end else begin
            slow_cnt_reg <= slow_cnt_reg + 16'h0001;
        end
    end
    assign slow_tick = slow_osc_run && (slow_cnt_reg == 16'(SLOW_DIV - 1));

    // prescaler runs on cpu clock once started, outside wait, stop and protection
    assign pre_en = running_reg && !ctrl_reg.protect && cpu_clock_run
                    && !wait_mode && !stopped;

    wdpcs_prescaler u_pre (
        .mclk      (mclk),
        .resetn    (resetn),
        .enable    (pre_en),
        .ratio_sel (ctrl_reg.pre_ratio),
        .tick      (pre_tick)
    );

    // count source select
    assign tick = ctrl_reg.protect ? (running_reg && slow_tick)
                                   : pre_tick;
    assign underflow = tick && (count_reg == '0);

    always_comb begin
        count_next = count_reg;
        if (protect_set) begin
            count_next = `WDP_RELOAD_PROT;
        end else if (refresh_fire || underflow) begin
            count_next = ctrl_reg.protect ? `WDP_RELOAD_PROT
                                          : `WDP_RELOAD_NORM;
        end else if (tick) begin
            count_next = count_reg - `WDP_CW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            count_reg <= !boot_option_word[`WDP_OPT_PROTECT] ? `WDP_RELOAD_PROT
                                                              : `WDP_RELOAD_NORM;
        end else begin
            count_reg <= count_next;
        end
    end

    // underflow action
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wdt_reset_reg <= 1'b0;
            wdt_irq_reg   <= 1'b0;
        end else begin
            wdt_reset_reg <= underflow && (ctrl_reg.protect || ctrl_reg.uf_action);
            wdt_irq_reg   <= underflow && !ctrl_reg.protect && !ctrl_reg.uf_action;
        end
    end
    assign wdt_reset = wdt_reset_reg;
    assign wdt_irq   = wdt_irq_reg;

    // checks
    chk_refresh_reload: assert property (@(posedge mclk) disable iff (!resetn)
        refresh_fire && !protect_set |=> count_reg == (ctrl_reg.protect ?
            `WDP_RELOAD_PROT : `WDP_RELOAD_NORM))
        else $error("refresh did not reload counter");

    chk_prot_load: assert property (@(posedge mclk) disable iff (!resetn)
        protect_set |=> ctrl_reg.protect && count_reg == `WDP_RELOAD_PROT)
        else $error("protect set did not load 0FFFh");

    chk_prot_osc: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.protect |-> slow_osc_run)
        else $error("slow oscillator stopped while protected");

    chk_prot_action: assert property (@(posedge mclk) disable iff (!resetn)
        protect_set |=> ctrl_reg.uf_action [*2])
        else $error("underflow action not forced to reset");

    chk_prot_reset: assert property (@(posedge mclk) disable iff (!resetn)
        underflow && ctrl_reg.protect |=> wdt_reset && !wdt_irq)
        else $error("protected underflow did not reset");

    chk_stop_block: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.protect && wr_acc && hit(avs_address, `WDP_A_CLKCTRL)
        |=> $stable(ctrl_reg.stop_req) && !stop_mode_req)
        else $error("stop request changed while protected");

    chk_sticky_prot: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.protect |=> ctrl_reg.protect)
        else $error("protect enable cleared");

    chk_wait_freeze: assert property (@(posedge mclk) disable iff (!resetn)
        !ctrl_reg.protect && wait_mode && !wr_acc |=> $stable(count_reg))
        else $error("count moved in wait mode");

    chk_prot_step: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.protect && slow_tick && running_reg && count_reg != '0 && !wr_acc
        |=> count_reg == $past(count_reg) - `WDP_CW'(1))
        else $error("protected count did not step");

    chk_irq_select: assert property (@(posedge mclk) disable iff (!resetn)
        underflow && !ctrl_reg.protect && !ctrl_reg.uf_action |=> wdt_irq && !wdt_reset)
        else $error("interrupt not raised on underflow");

    chk_auto_start: assert property (@(posedge mclk)
        !resetn && !boot_option_word[`WDP_OPT_AUTOSTART] |=> running_reg)
        else $error("auto start did not run");

    chk_hold_start: assert property (@(posedge mclk) disable iff (!resetn)
        !running_reg |-> !tick && !pre_en)
        else $error("counted before start");

    chk_osc_lock: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.protect && wr_acc && hit(avs_address, `WDP_A_CLKCTRL)
        |=> $stable(ctrl_reg.slow_stop) && slow_osc_run)
        else $error("slow oscillator stop changed while protected");

    chk_prot_no_irq: assert property (@(posedge mclk) disable iff (!resetn)
        $past(ctrl_reg.protect) && ctrl_reg.protect |-> !wdt_irq)
        else $error("interrupt raised while protected");

    chk_prot_wait: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.protect && running_reg && wait_mode && slow_tick && count_reg != '0
        && !wr_acc |=> count_reg == $past(count_reg) - `WDP_CW'(1))
        else $error("protected count stalled in wait mode");

    chk_action_lock: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl_reg.protect |-> ctrl_reg.uf_action)
        else $error("underflow action not reset while protected");

    chk_option_fixed: assert property (@(posedge mclk) disable iff (!resetn)
        resetn |=> $stable(opt_reg))
        else $error("option word changed outside reset");

    chk_read_protect: assert property (@(posedge mclk) disable iff (!resetn)
        rd_acc && hit(avs_address, `WDP_A_PROTECT)
        |-> avs_readdata[`WDP_B_PROTECT] == ctrl_reg.protect)
        else $error("protect enable read back wrong");

    chk_stop_freeze: assert property (@(posedge mclk) disable iff (!resetn)
        !ctrl_reg.protect && stop_mode_req && !wr_acc |=> $stable(count_reg))
        else $error("count moved in stop mode");

endmodule : wdpcs_top
`default_nettype wire

//--- wdpcs_top_tb.sv
// self-checking bench for the protected watchdog
`default_nettype none
`include "wdpcs_cfg.svh"
module wdpcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SD = 4;
    logic              mclk = 1'b0;
    logic              resetn = 1'b0;
    logic [4:0]        avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [7:0]        boot_option_word;
    logic              cpu_clock_run;
    logic              wait_mode;
    logic              stop_wake;
    logic              stop_mode_req;
    logic              slow_osc_run;
    logic              wdt_reset;
    logic              wdt_irq;
    int                err_total = 0;
    int                n_tests = 0;
    int                cyc = 0;
    int                irq_cnt = 0;
    int                t0;
    logic [31:0]       q;
    logic [31:0]       q2;

    always #10 mclk = ~mclk;

    wdpcs_top #(.SLOW_DIV(SD)) dut (
        .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .boot_option_word(boot_option_word),
        .cpu_clock_run(cpu_clock_run), .wait_mode(wait_mode), .stop_wake(stop_wake),
        .stop_mode_req(stop_mode_req), .slow_osc_run(slow_osc_run), .wdt_reset(wdt_reset),
        .wdt_irq(wdt_irq)
    );

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            $display("MISMATCH %0t timeout", $time);
            print_verdict();
        end
    end

    always @(negedge mclk) if (wdt_irq === 1'b1) irq_cnt++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string msg);
        n_tests++;
        if (!((^got !== 1'bx) && got >= lo && got <= hi)) begin
            err_total++;
            $display("MISMATCH %0t %s got %0h range %0h..%0h", $time, msg, got, lo, hi);
        end
    endtask : chk_rng

    // one avalon transfer, held until the rising edge that sees waitrequest low
    task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        avs_read <= rd;
        avs_write <= ~rd;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        chk(n, 32'h2, "one wait state");
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'b0, a, d, dummy);
    endtask : wr

    task automatic rst(input logic [7:0] opt);
        @(posedge mclk);
        resetn <= 1'b0;
        boot_option_word <= opt;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
    endtask : rst

    initial begin
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        boot_option_word = 8'hFF;
        cpu_clock_run = 1'b1;
        wait_mode = 1'b0;
        stop_wake = 1'b0;
        // held after reset, unprotected
        rst(8'hFF);
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk({q[31:24], q[16], q[14:0]}, {8'hFF, 1'b0, 15'h7FFF}, "status after reset");
        chk({31'h0, slow_osc_run}, 32'h0, "slow osc off");
        wr(`WDP_A_STATUS, 32'h0);
        repeat (100) @(posedge mclk);
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk({q[31:24], q[16], q[14:0]}, {8'hFF, 1'b0, 15'h7FFF}, "held, option fixed");
        bus(1'b1, 5'h1C, 0, q);
        chk(q, 32'h0, "unmapped read");
        $display("test held done");
        // start, arm cancel and refresh
        wr(`WDP_A_START, 32'h0);
        repeat (1600) @(posedge mclk);
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk({31'h0, q[16]}, 32'h1, "running after start");
        chk_rng(q[14:0], 15'h7FFF - 102, 15'h7FFF - 98, "count after start");
        wr(`WDP_A_REFRESH, 32'h00);
        wr(`WDP_A_REFRESH, 32'h55);
        wr(`WDP_A_REFRESH, 32'hFF);
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk_rng(q[14:0], 0, 15'h7FFF - 90, "cancelled refresh");
        wr(`WDP_A_REFRESH, 32'h00);
        wr(`WDP_A_REFRESH, 32'hFF);
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk_rng(q[14:0], 15'h7FFF - 1, 15'h7FFF, "refresh reload");
        $display("test refresh done");
        // prescaler ratio 128 then 16
        for (int i = 0; i < 2; i++) begin
            wr(`WDP_A_WDCTRL, (i == 0) ? 32'h80 : 32'h00);
            bus(1'b1, `WDP_A_STATUS, 0, q);
            repeat ((i == 0) ? 1280 : 160) @(posedge mclk);
            bus(1'b1, `WDP_A_STATUS, 0, q2);
            chk_rng(q[14:0] - q2[14:0], 9, 11, "ticks per ratio");
        end
        $display("test ratio done");
        // freeze in wait, stop and with cpu clock halted
        for (int i = 0; i < 3; i++) begin
            wait_mode <= (i == 0);
            cpu_clock_run <= (i != 2);
            if (i == 1) begin
                wr(`WDP_A_CLKCTRL, 32'h01);
                @(posedge mclk);
                chk({31'h0, stop_mode_req}, 32'h1, "stop request");
            end
            bus(1'b1, `WDP_A_STATUS, 0, q);
            repeat (200) @(posedge mclk);
            bus(1'b1, `WDP_A_STATUS, 0, q2);
            chk(q2[14:0], q[14:0], "count frozen");
            if (i == 1) begin
                stop_wake <= 1'b1;
                @(posedge mclk);
                stop_wake <= 1'b0;
                @(posedge mclk);
                chk({31'h0, stop_mode_req}, 32'h0, "stop left");
            end
        end
        cpu_clock_run <= 1'b1;
        $display("test freeze done");
        // enable protection at run time
        wr(`WDP_A_PROTECT, 32'h1);
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk_rng(q[14:0], 15'h0FFF - 2, 15'h0FFF, "protect load");
        chk({31'h0, slow_osc_run}, 32'h1, "slow osc on");
        wr(`WDP_A_PMODE, 32'h0);
        bus(1'b1, `WDP_A_PMODE, 0, q);
        chk({31'h0, q[2]}, 32'h1, "action forced reset");
        wr(`WDP_A_CLKCTRL, 32'h11);
        @(posedge mclk);
        chk({30'h0, stop_mode_req, slow_osc_run}, 32'h1, "clkctrl locked");
        wr(`WDP_A_PROTECT, 32'h0);
        bus(1'b1, `WDP_A_PROTECT, 0, q);
        chk({31'h0, q[0]}, 32'h1, "protect sticky");
        wait_mode <= 1'b1;
        cpu_clock_run <= 1'b0;
        irq_cnt = 0;
        wr(`WDP_A_REFRESH, 32'h00);
        wr(`WDP_A_REFRESH, 32'hFF);
        t0 = cyc;
        while (wdt_reset !== 1'b1 && cyc - t0 < 20000) @(negedge mclk);
        chk_rng(cyc - t0, 4095 * SD - 2, 4096 * SD + 3, "protected period");
        chk(irq_cnt, 0, "no interrupt");
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk_rng(q[14:0], 15'h0FFF - 2, 15'h0FFF, "underflow reload");
        wait_mode <= 1'b0;
        cpu_clock_run <= 1'b1;
        $display("test protect done");
        // protection from power-up, auto start
        rst(8'h7E);
        bus(1'b1, `WDP_A_PROTECT, 0, q);
        chk({31'h0, q[0]}, 32'h1, "powerup protect");
        chk({31'h0, slow_osc_run}, 32'h1, "powerup slow osc");
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk({31'h0, q[16]}, 32'h1, "auto run");
        chk_rng(q[14:0], 15'h0FFF - 2, 15'h0FFF, "powerup count");
        rst(8'hFE);
        bus(1'b1, `WDP_A_STATUS, 0, q);
        chk({31'h0, q[16]}, 32'h1, "auto run unprotected");
        bus(1'b1, `WDP_A_PROTECT, 0, q);
        chk({31'h0, q[0]}, 32'h0, "unprotected");
        $display("test powerup done");
        print_verdict();
    end
endmodule : wdpcs_top_tb
`default_nettype wire
